// file: security_sector_erase.v
// Functional notes
// - One 1024-byte security sector, separate from and addressed apart from main array.
// - Erase accepted only while write enable latch is 1; host sends write enable first.
// - Select must rise right after 32nd bit; otherwise erase is discarded.
// - Valid command starts self-timed erase lasting the sector erase time.
// - Read-status still answered while erase runs.
// - Write in progress reads 1 during erase, 0 after; then commands accepted.
// - Erase completion clears the write enable latch.
// - Lock bit set makes every security erase ignored until reset.
// - Every sector byte reads FFh after erase.
`timescale 1ns/1ps
`default_nettype none
`include "sec_erase_consts.vh"
module security_sector_erase #(
   parameter ERASE_CYCLES = `SECTOR_ERASE_CYCLES
) (
   input wire ref_clk_in,
   input wire rstn_in,
   input wire cs_n_in,
   input wire sclk_in,
   input wire mosi_in,
   input wire lock_bit_in,
   input wire [`SEC_ADDR_W-1:0] rd_addr_in,
   output reg miso_out,
   output reg miso_oe_out,
   output reg write_in_progress_out,
   output reg write_enable_latch_out,
   output reg [7:0] rd_data_out
);
   localparam ST_IDLE = 2'd0;
   localparam ST_ERASE = 2'd1;
   reg [1:0] cs_sync_ff, clk_sync_ff, di_sync_ff;
   reg cs_d_ff, clk_d_ff;
   reg [5:0] bit_cnt_ff;
   reg [31:0] shift_ff;
   reg [7:0] out_sh_ff;
   reg [1:0] state_ff;
   reg [31:0] timer_ff;
   reg [`SEC_ADDR_W-1:0] wipe_ptr_ff;
   reg lock_ff;
   // Lock pin is asynchronous, so it is synced like the link pins
   reg [1:0] lock_sync_ff;
   wire [7:0] mem_q;
   wire cs_low = ~cs_sync_ff[1];
   wire cs_rise = cs_sync_ff[1] & ~cs_d_ff;
   wire clk_rise = clk_sync_ff[1] & ~clk_d_ff;
   wire clk_fall = ~clk_sync_ff[1] & clk_d_ff;
   wire busy = (state_ff == ST_ERASE);
   wire [7:0] opc = shift_ff[31:24];
   wire [7:0] nxt_shift_byte = {shift_ff[6:0], di_sync_ff[1]};
   wire frame_ok = (bit_cnt_ff == `CMD_BITS) && (opc == `OPC_ERASE_SEC);
   wire addr_ok = (shift_ff[23:10] == 14'h0000);
   sec_sector_mem #(.AW(`SEC_ADDR_W), .DW(8)) u_mem (
      .clk_in(ref_clk_in),
      .wr_en_in(busy),
      .wr_addr_in(wipe_ptr_ff),
      .wr_data_in(`ERASED_BYTE),
      .rd_addr_in(rd_addr_in),
      .rd_data_out(mem_q)
   );
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cs_sync_ff <= 2'b11;
         clk_sync_ff <= 2'b00;
         di_sync_ff <= 2'b00;
         cs_d_ff <= 1'b1;
         clk_d_ff <= 1'b0;
         lock_sync_ff <= 2'b00;
         lock_ff <= 1'b0;
      end else begin
         lock_sync_ff <= {lock_sync_ff[0], lock_bit_in};
         cs_sync_ff <= {cs_sync_ff[0], cs_n_in};
         clk_sync_ff <= {clk_sync_ff[0], sclk_in};
         di_sync_ff <= {di_sync_ff[0], mosi_in};
         cs_d_ff <= cs_sync_ff[1];
         clk_d_ff <= clk_sync_ff[1];
         if (lock_sync_ff[1]) begin
            lock_ff <= 1'b1;
         end
      end
   end
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         bit_cnt_ff <= 6'd0;
         shift_ff <= 32'h00000000;
         out_sh_ff <= 8'h00;
         miso_out <= 1'b0;
         miso_oe_out <= 1'b0;
         state_ff <= ST_IDLE;
         timer_ff <= 32'h00000000;
         wipe_ptr_ff <= {`SEC_ADDR_W{1'b0}};
         write_in_progress_out <= 1'b0;
         write_enable_latch_out <= 1'b0;
         rd_data_out <= 8'h00;
      end else begin
         rd_data_out <= mem_q;
         if (!cs_low) begin
            bit_cnt_ff <= 6'd0;
            miso_oe_out <= 1'b0;
         end else if (clk_rise) begin
            shift_ff <= {shift_ff[30:0], di_sync_ff[1]};
            if (bit_cnt_ff != 6'd63) begin
               bit_cnt_ff <= bit_cnt_ff + 6'd1;
            end
            if (bit_cnt_ff == 6'd7) begin
               if (nxt_shift_byte == `OPC_READ_STAT1) begin
                  out_sh_ff <= {6'd0, write_enable_latch_out, write_in_progress_out};
                  miso_oe_out <= 1'b1;
               end else if (nxt_shift_byte == `OPC_READ_STAT2) begin
                  out_sh_ff <= {5'd0, lock_ff, 2'b00};
                  miso_oe_out <= 1'b1;
               end
            end
         end else if (clk_fall && miso_oe_out) begin
            miso_out <= out_sh_ff[7];
            out_sh_ff <= {out_sh_ff[6:0], out_sh_ff[7]};
         end
         case (state_ff)
            ST_IDLE: begin
               if (cs_rise && bit_cnt_ff == 6'd8 && opc_low(shift_ff) == `OPC_WRITE_EN) begin
                  write_enable_latch_out <= 1'b1;
               end else if (cs_rise && bit_cnt_ff == 6'd8 &&
                            opc_low(shift_ff) == `OPC_WRITE_DIS) begin
                  write_enable_latch_out <= 1'b0;
               end
               if (cs_rise && frame_ok && addr_ok && write_enable_latch_out && !lock_ff) begin
                  state_ff <= ST_ERASE;
                  timer_ff <= ERASE_CYCLES - 1;
                  wipe_ptr_ff <= {`SEC_ADDR_W{1'b0}};
                  write_in_progress_out <= 1'b1;
               end
            end
            ST_ERASE: begin
               wipe_ptr_ff <= wipe_ptr_ff + 1'b1;
               if (timer_ff == 32'h00000000) begin
                  state_ff <= ST_IDLE;
                  write_in_progress_out <= 1'b0;
                  write_enable_latch_out <= 1'b0;
               end else begin
                  timer_ff <= timer_ff - 32'h00000001;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end
   function [7:0] opc_low;
      input [31:0] sh;
      begin
         opc_low = sh[7:0];
      end
   endfunction
endmodule
`default_nettype wire

// file: sec_erase_consts.vh
`ifndef SEC_ERASE_CONSTS_VH
`define SEC_ERASE_CONSTS_VH
`define OPC_ERASE_SEC 8'h44
`define OPC_WRITE_EN 8'h06
`define OPC_WRITE_DIS 8'h04
`define OPC_READ_STAT1 8'h05
`define OPC_READ_STAT2 8'h35
`define SEC_BYTES 1024
`define SEC_ADDR_W 10
`define CMD_BITS 32
`define ERASED_BYTE 8'hff
`define STAT1_WIP_POS 0
`define STAT1_WEL_POS 1
`define STAT2_LOCK_POS 2
`define SECTOR_ERASE_TIME_US 300
`define CLK_MHZ 250
`define SECTOR_ERASE_CYCLES (`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`endif

// file: sec_sector_mem.v
`timescale 1ns/1ps
`default_nettype none
module sec_sector_mem #(
   parameter AW = 10,
   parameter DW = 8
) (
   input wire clk_in,
   input wire wr_en_in,
   input wire [AW-1:0] wr_addr_in,
   input wire [DW-1:0] wr_data_in,
   input wire [AW-1:0] rd_addr_in,
   output reg [DW-1:0] rd_data_out
);
   reg [DW-1:0] mem [0:(1<<AW)-1];
   always @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule
`default_nettype wire

// file: erase_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module erase_monitor #(parameter ERASE_CYCLES = 2000) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic cs_n_in,
   input wire logic lock_bit_in,
   input wire logic write_in_progress_out,
   input wire logic write_enable_latch_out
);
   wire write_in_progress = write_in_progress_out;
   wire write_enable_latch = write_enable_latch_out;
   reg [31:0] cnt_ff;
   reg lock_ff;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // Busy length and sticky lock
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_ff <= 32'h0;
         lock_ff <= 1'b0;
      end else begin
         cnt_ff <= write_in_progress ? cnt_ff + 32'h1 : 32'h0;
         lock_ff <= lock_ff | lock_bit_in;
      end
   end
   no_start_a: assert property (!write_enable_latch |=> !$rose(write_in_progress)) else $error("start w/o latch");
   lock_block_a: assert property (lock_ff |-> !$rose(write_in_progress)) else $error("start locked");
   cs_high_a: assert property ($rose(write_in_progress) |-> cs_n_in) else $error("start in frame");
   erase_len_a: assert property ($fell(write_in_progress) |-> cnt_ff == ERASE_CYCLES) else $error("len");
   wip_run_a: assert property ($rose(write_in_progress) |-> write_in_progress [*8]) else $error("busy short");
   wel_clear_a: assert property ($fell(write_in_progress) |-> !write_enable_latch) else $error("latch kept");
   wel_hold_a: assert property (write_in_progress |-> write_enable_latch) else $error("latch dropped early");
   busy_wel_a: assert property (write_in_progress |=> !$rose(write_enable_latch)) else $error("cmd taken busy");
   cover property ($rose(write_in_progress));
   cover property ($fell(write_in_progress));
   cover property ($rose(lock_ff));
endmodule
bind security_sector_erase erase_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) erase_monitor_inst (
   .ref_clk_in, .rstn_in, .cs_n_in, .lock_bit_in, .write_in_progress_out, .write_enable_latch_out);
`default_nettype wire

// file: spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output logic cs_n_out,
   output logic sclk_out,
   output logic mosi_out,
   input wire logic miso_in
);
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      mosi_out = 1'b0;
   end
   task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] r);
      r = 8'h00;
      cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_out = d[i];
         #16 sclk_out = 1'b1;
         r = {r[6:0], miso_in};
         #16 sclk_out = 1'b0;
      end
      #16 cs_n_out = 1'b1;
      // Idle data line must not look valid
      mosi_out = ~mosi_out;
   endtask
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk_in = 1'b0, rstn_in = 1'b0, lock_bit_in = 1'b0;
   logic [9:0] rd_addr_in = 10'h000;
   logic [7:0] st;
   wire cs_n, sclk, mosi, miso, oe, write_in_progress, write_enable_latch;
   wire [7:0] rd_data;
   int num_errors = 0, num_checks = 0;
   typedef struct packed {logic wen; logic busy; logic [5:0] n; logic [31:0] fr;} row_t;
   row_t rows [5] = '{{1'b0, 1'b0, 6'h20, 32'h44000000}, {1'b1, 1'b0, 6'h20, 32'h44000400},
      {1'b1, 1'b0, 6'h1f, 32'h22000000}, {1'b1, 1'b0, 6'h18, 32'h00440000},
      {1'b1, 1'b1, 6'h20, 32'h440003ff}};
   security_sector_erase #(.ERASE_CYCLES(2000)) security_sector_erase_inst (.ref_clk_in,
      .rstn_in, .cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi), .lock_bit_in, .rd_addr_in,
      .miso_out(miso), .miso_oe_out(oe), .write_in_progress_out(write_in_progress),
      .write_enable_latch_out(write_enable_latch), .rd_data_out(rd_data));
   spi_host_model spi_host_model_inst (.cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi),
      .miso_in(miso));
   task chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task host(input logic [31:0] d, input int n);
      repeat (6) @(posedge ref_clk_in);
      #1 spi_host_model_inst.xfer(d, n, st);
   endtask
   task report_and_stop;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial forever #2 ref_clk_in = ~ref_clk_in;
   initial begin
      repeat (6) @(posedge ref_clk_in);
      #1 rstn_in = 1'b1;
      chk(write_in_progress, 1'b0);
      chk(write_enable_latch, 1'b0);
      for (int k = 0; k < 5; k++) begin
         if (rows[k].wen)
            host(32'h06, 8);
         host(rows[k].fr, rows[k].n);
         repeat (8) @(posedge ref_clk_in);
         #1 chk(write_in_progress, rows[k].busy);
         chk(write_enable_latch, rows[k].wen);
         chk(oe, 1'b0);
         if (rows[k].busy) begin
            host(32'h0500, 16);
            chk(st, 8'h03);
            for (int t = 0; t < 100 && st[0] !== 1'b0; t++)
               host(32'h0500, 16);
            chk(st, 8'h00);
            if (st !== 8'h00)
               report_and_stop;
            for (int a = 0; a < 1024; a++) begin
               rd_addr_in = a[9:0];
               repeat (3) @(posedge ref_clk_in);
               #1 chk(rd_data, 8'hff);
            end
         end
         $display("row %0d done", k);
      end
      lock_bit_in = 1'b1;
      @(posedge ref_clk_in);
      #1 lock_bit_in = 1'b0;
      host(32'h06, 8);
      host(32'h44000000, 32);
      repeat (8) @(posedge ref_clk_in);
      #1 chk(write_enable_latch, 1'b1);
      chk(write_in_progress, 1'b0);
      host(32'h3500, 16);
      chk(st[2], 1'b1);
      $display("lock test done");
      // Reset must clear lock; reset in mid-erase must clear busy and latch
      rstn_in = 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1 rstn_in = 1'b1;
      chk(write_in_progress, 1'b0);
      chk(write_enable_latch, 1'b0);
      host(32'h06, 8);
      host(32'h44000000, 32);
      repeat (8) @(posedge ref_clk_in);
      #1 chk(write_in_progress, 1'b1);
      rstn_in = 1'b0;
      repeat (2) @(posedge ref_clk_in);
      #1 chk(write_in_progress, 1'b0);
      chk(write_enable_latch, 1'b0);
      rstn_in = 1'b1;
      $display("reset test done");
      report_and_stop;
   end
endmodule
`default_nettype wire
